// [hdl/lvd_consts.svh]
// Constants for the low-voltage detector control block
`ifndef LVD_CONSTS_SVH
`define LVD_CONSTS_SVH
`define LVD_REG_ADDR      6'h06
`define LVD_BIT_FLAG      6
`define LVD_BIT_STATUS_N  5
`define LVD_BIT_IRQ_EN    4
`define LVD_BIT_WAKE_EN   3
`define LVD_BIT_DET_EN    2
`define LVD_BIT_SEL_HI    1
`define LVD_BIT_SEL_LO    0
`define LVD_CTRL_RESET    5'h00
`define LVD_CLK_MHZ       100
`define LVD_BROWNOUT_US   80
`define LVD_BROWNOUT_CYC  (`LVD_BROWNOUT_US * `LVD_CLK_MHZ)
`endif

// [hdl/lvd_pkg.sv]
// Types shared by the low-voltage detector control block
package lvd_pkg;
  typedef logic [1:0] lvd_level_t;  // Threshold select code
  typedef enum logic [1:0] {
    LVD_RUN  = 2'b00,  // Supply fine, core runs
    LVD_HALT = 2'b01,  // Short brownout, core halted
    LVD_RST  = 2'b10   // Long brownout, system reset
  } lvd_bo_e;
endpackage

// [hdl/lvd_sync.sv]
// Two-flop synchroniser for asynchronous comparator levels
`timescale 1ns/1ps
module lvd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;  // First stage, read only by second stage

  // Reset value 1 means "supply good" for active-low comparator inputs
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta   <= '1;
      o_sync <= '1;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule // lvd_sync

// [hdl/lvd_ctrl.sv]
// Low-voltage detector control register, event and brownout logic
`timescale 1ns/1ps
`include "lvd_consts.svh"
module lvd_ctrl import lvd_pkg::*; #(
  parameter int BROWNOUT_CYC = `LVD_BROWNOUT_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  input  wire logic [5:0] i_reg_addr,     // Register address in bank 1
  input  wire logic       i_reg_wr,       // Write strobe, one cycle
  input  wire logic [7:0] i_reg_wdata,    // Write data
  output logic      [7:0] o_reg_rdata,    // Read data, zero off-address
  input  wire logic [3:0] i_below_lvl_n,  // Async comparators, 0 = at/below level k
  input  wire logic       i_below_rst_n,  // Async comparator, 0 = below reset level
  input  wire logic       i_irq_on_instr, // Enable-interrupt instruction pulse
  input  wire logic       i_irq_off_instr,// Disable-interrupt instruction pulse
  input  wire logic       i_sleeping,     // Core is asleep
  output logic            o_irq_req,      // Interrupt vector request
  output logic            o_wake_req,     // Wake from sleep request
  output logic            o_halt,         // Halt core, keep registers
  output logic            o_sys_reset     // Full system reset request
);
  logic [3:0] lvl_n_s;      // Synchronised level comparators
  logic       rst_n_s;      // Synchronised reset comparator
  logic       lowv_irq_flag;
  logic       lowv_irq_en;
  logic       lowv_wake_en;
  logic       lowv_detect_en;
  lvd_level_t lowv_level_sel;
  logic       global_irq_en;  // Global gate
  lvd_bo_e    bo_state;
  lvd_bo_e    next_bo_state;
  logic [$clog2(BROWNOUT_CYC+1)-1:0] bo_cnt;  // Brownout length counter

  // Comparators are analog, so both pass two flops first
  lvd_sync #(.WIDTH(5)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_async   ({i_below_rst_n, i_below_lvl_n}),
    .o_sync    ({rst_n_s, lvl_n_s})
  );

  // Index 3 = 2.3 V, 2 = 3.3 V, 1 = 4.0 V, 0 = 4.5 V
  wire        low_now   = lowv_detect_en & ~lvl_n_s[lowv_level_sel];
  wire        lowv_status_n = ~low_now;
  wire        reg_sel   = (i_reg_addr == `LVD_REG_ADDR);
  wire        reg_wr    = reg_sel & i_reg_wr;
  wire        clr_flag  = reg_wr & ~i_reg_wdata[`LVD_BIT_FLAG];
  wire        set_flag  = low_now;

  // Status bit ignores writes; flag only accepts clearing writes
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lowv_irq_flag  <= 1'b0;
      lowv_irq_en    <= 1'b0;
      lowv_wake_en   <= 1'b0;
      lowv_detect_en <= 1'b0;
      lowv_level_sel <= 2'h0;
    end else begin
      // Set wins, so a detection during a clear is not lost
      if (set_flag) begin
        lowv_irq_flag <= 1'b1;
      end else if (clr_flag) begin
        lowv_irq_flag <= 1'b0;
      end
      if (reg_wr) begin
        lowv_irq_en    <= i_reg_wdata[`LVD_BIT_IRQ_EN];
        lowv_wake_en   <= i_reg_wdata[`LVD_BIT_WAKE_EN];
        lowv_detect_en <= i_reg_wdata[`LVD_BIT_DET_EN];
        lowv_level_sel <= i_reg_wdata[`LVD_BIT_SEL_HI:`LVD_BIT_SEL_LO];
      end
    end
  end

  // Global gate follows the two instructions; off wins a tie
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      global_irq_en <= 1'b0;
    end else if (i_irq_off_instr) begin
      global_irq_en <= 1'b0;
    end else if (i_irq_on_instr) begin
      global_irq_en <= 1'b1;
    end
  end

  // Registered data readback; bit 7 reads zero
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= reg_sel ? {1'b0, lowv_irq_flag, lowv_status_n, lowv_irq_en,
                                lowv_wake_en, lowv_detect_en, lowv_level_sel}
                             : 8'h00;
    end
  end

  // Requests: interrupt needs both gates, wake its own enable and a sleeping core
  assign o_irq_req  = lowv_irq_flag & lowv_irq_en & global_irq_en;
  assign o_wake_req = lowv_irq_flag & lowv_wake_en & i_sleeping;

  // Brownout: halt at once, reset once the dip outlasts the limit
  always_comb begin
    next_bo_state = bo_state;
    case (bo_state)
      LVD_RUN:  if (!rst_n_s) next_bo_state = LVD_HALT;
      LVD_HALT: begin
        if (rst_n_s) begin
          next_bo_state = LVD_RUN;
        end else if (bo_cnt >= BROWNOUT_CYC[$bits(bo_cnt)-1:0]) begin
          next_bo_state = LVD_RST;
        end
      end
      LVD_RST:  if (rst_n_s) next_bo_state = LVD_RUN;
      default:  next_bo_state = LVD_RUN;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bo_state <= LVD_RUN;
      bo_cnt   <= '0;
    end else begin
      bo_state <= next_bo_state;
      // Counter runs only while halted, saturating at the limit
      if (bo_state != LVD_HALT) begin
        bo_cnt <= '0;
      end else if (bo_cnt < BROWNOUT_CYC[$bits(bo_cnt)-1:0]) begin
        bo_cnt <= bo_cnt + 1'b1;
      end
    end
  end

  assign o_halt      = (bo_state == LVD_HALT);
  assign o_sys_reset = (bo_state == LVD_RST);

  // Checks
  flag_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    low_now |=> lowv_irq_flag) else $error("flag not set on low");
  flag_sticky_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    lowv_irq_flag && !clr_flag |=> lowv_irq_flag) else $error("flag lost");
  flag_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !lowv_irq_flag && !low_now |=> !lowv_irq_flag) else $error("spurious flag");
  irq_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_irq_req |-> lowv_irq_en && global_irq_en) else $error("irq not gated");
  wake_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_wake_req |-> lowv_wake_en) else $error("wake not gated");
  gate_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_irq_off_instr |=> !o_irq_req) else $error("gate stays open");
  status_dis_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !lowv_detect_en |-> lowv_status_n) else $error("status low when off");
  halt_short_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(o_halt) |-> !o_sys_reset [*8]) else $error("early reset");
  bo_reset_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_halt && bo_cnt >= BROWNOUT_CYC[$bits(bo_cnt)-1:0] && !rst_n_s |=> o_sys_reset)
    else $error("no reset on long brownout");
endmodule // lvd_ctrl

// [verif/lvd_core_model.sv]
// Behavioural core: enters sleep on command, leaves it on a wake request
`timescale 1ns/1ps
module lvd_core_model (
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  input  wire logic i_sleep_cmd,
  input  wire logic i_wake_req,
  output logic      o_sleeping
);
  // Sleep state; reset wakes the core
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) o_sleeping <= 1'b0;
    else if (o_sleeping && i_wake_req) o_sleeping <= 1'b0;
    else if (i_sleep_cmd) o_sleeping <= 1'b1;
  end
endmodule // lvd_core_model

// [verif/tb_lvd_ctrl.sv]
// Self-checking bench for the low-voltage detector control block
`timescale 1ns/1ps
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module tb_lvd_ctrl;
  logic       i_clk_sys = 0, i_reset_n = 0, i_reg_wr = 0, i_below_rst_n = 1, slp = 0;
  logic       i_irq_on_instr = 0, i_irq_off_instr = 0, i_sleeping, flag = 0;
  logic       o_irq_req, o_wake_req, o_halt, o_sys_reset;
  logic [5:0] i_reg_addr = 6'h06;
  logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata;
  logic [3:0] i_below_lvl_n = 4'hf;
  logic [4:0] ctrl = 5'h00; // Model copy of the writable fields
  int         n_mismatch = 0, tests_run = 0, vdd = 50, i;
  integer     seed = 32'hbea1bbf7;
  always #5 i_clk_sys = ~i_clk_sys;
  // Short brownout count keeps the run brief
  lvd_ctrl #(.BROWNOUT_CYC(20)) lvd_ctrl_i (.i_clk_sys, .i_reset_n, .i_reg_addr, .i_reg_wr,
    .i_reg_wdata, .o_reg_rdata, .i_below_lvl_n, .i_below_rst_n, .i_irq_on_instr,
    .i_irq_off_instr, .i_sleeping, .o_irq_req, .o_wake_req, .o_halt, .o_sys_reset);
  lvd_core_model lvd_core_model_i (.i_clk_sys, .i_reset_n, .i_sleep_cmd(slp),
    .i_wake_req(o_wake_req), .o_sleeping(i_sleeping));
  // Levels in tenths of a volt
  function automatic int thr(logic [1:0] s);
    return s == 2'd3 ? 23 : s == 2'd2 ? 33 : s == 2'd1 ? 40 : 45;
  endfunction
  function automatic logic det();
    return ctrl[2] && vdd <= thr(ctrl[1:0]);
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic lim(int n);
    if (i >= n) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  // Let the synchroniser pass, then a held detection sets the flag
  task automatic settle();
    repeat (4) @(negedge i_clk_sys);
    if (det()) flag = 1;
  endtask
  task automatic sup(int v);
    vdd = v;
    i_below_lvl_n = {v > 23, v > 33, v > 40, v > 45};
    settle();
  endtask
  task automatic wr(logic [7:0] d);
    i_reg_wdata = d;
    i_reg_wr = 1;
    @(negedge i_clk_sys) i_reg_wr = 0;
    // Detection under the old setting still wins the clearing edge
    if (!d[6] && !det()) flag = 0;
    ctrl = d[4:0];
    settle();
  endtask
  task automatic rd(logic [5:0] a);
    i_reg_addr = a;
    repeat (2) @(negedge i_clk_sys);
    `CHK(o_reg_rdata, a == 6'h06 ? {1'b0, flag, !det(), ctrl} : 8'h00)
    i_reg_addr = 6'h06;
  endtask
  initial begin
    repeat (3) @(negedge i_clk_sys);
    i_reset_n = 1;
    rd(6'h06);
    rd(6'h07);
    for (int s = 0; s < 4; s++) begin
      wr({6'h01, s[1:0]});
      sup(thr(s[1:0]) + 1);
      rd(6'h06);
      sup(thr(s[1:0]));
      sup(50);
      rd(6'h06);
      wr({6'h01, s[1:0]});
      rd(6'h06);
    end
    repeat (30) begin
      wr(8'($random(seed)));
      sup(20 + {$random(seed)} % 31);
      rd(6'h06);
    end
    sup(50);
    wr(8'h04);
    slp = 1;
    @(negedge i_clk_sys) slp = 0;
    sup(20);
    `CHK(i_sleeping, 1'b1)
    rd(6'h06);
    wr(8'h0c);
    `CHK(i_sleeping, 1'b0)
    rd(6'h06);
    i_irq_on_instr = 1;
    @(negedge i_clk_sys) i_irq_on_instr = 0;
    `CHK(o_irq_req, 1'b0)
    wr(8'h14);
    `CHK(o_irq_req, 1'b1)
    i_irq_off_instr = 1;
    @(negedge i_clk_sys) i_irq_off_instr = 0;
    @(negedge i_clk_sys) `CHK(o_irq_req, 1'b0)
    i_below_rst_n = 0;
    for (i = 0; i < 6 && o_halt !== 1'b1; i++) @(negedge i_clk_sys);
    lim(6);
    i_below_rst_n = 1;
    for (i = 0; i < 6 && o_halt !== 1'b0; i++) @(negedge i_clk_sys);
    lim(6);
    rd(6'h06);
    i_below_rst_n = 0;
    repeat (12) @(negedge i_clk_sys);
    `CHK(o_sys_reset, 1'b0)
    for (i = 0; i < 20 && o_sys_reset !== 1'b1; i++) @(negedge i_clk_sys);
    lim(20);
    i_reset_n = 0;
    i_below_rst_n = 1;
    flag = 0;
    ctrl = 5'h00;
    repeat (3) @(negedge i_clk_sys);
    i_reset_n = 1;
    rd(6'h06);
    report_and_stop();
  end
endmodule // tb_lvd_ctrl
